/* include/timers_cfg.svh */
// Register map, field positions and codes for the three general timers.
// Assumes an 8-bit register port with byte-wide data.
`ifndef TIMERS_CFG_SVH
`define TIMERS_CFG_SVH

`define OFS_RUN_CTRL    8'h88
`define OFS_MODE_CTRL   8'h89
`define OFS_C0_LOW      8'h8A
`define OFS_C1_LOW      8'h8B
`define OFS_C0_HIGH     8'h8C
`define OFS_C1_HIGH     8'h8D
`define OFS_CLK_CTRL    8'h8E
`define OFS_T2_CTRL     8'hC8
`define OFS_T2_RLD_LOW  8'hCA
`define OFS_T2_RLD_HIGH 8'hCB
`define OFS_T2_LOW      8'hCC
`define OFS_T2_HIGH     8'hCD
`define OFS_IRQ_CFG     8'hE4
`define OFS_IRQ_STATUS  8'hE8
`define OFS_IRQ_MASK    8'hE9
`define OFS_T2_CTRL1    8'hFD

`define RST_BYTE        8'h00
`define BYTE_MAX        8'hFF

`define RUN_TF1 7
`define RUN_EN1 6
`define RUN_TF0 5
`define RUN_EN0 4
`define MOD_GATED1 7
`define MOD_CNT1   6
`define MOD_SEL1   5:4
`define MOD_GATED0 3
`define MOD_CNT0   2
`define MOD_SEL0   1:0
`define CKC_SYS0  2
`define CKC_SYS1  3
`define CKC_SYS2L 4
`define CKC_SYS2H 5
`define ICF_POL0 3
`define ICF_POL1 7
`define T2_HFLAG  7
`define T2_LFLAG  6
`define T2_LEN    5
`define T2_CEN    4
`define T2_SPLIT  3
`define T2_RUN    2
`define T2_XCLK   1:0
`define T2_CSEL   2:0

`define MODE_13BIT  2'h0
`define MODE_16BIT  2'h1
`define MODE_RELOAD 2'h2
`define MODE_SPLIT  2'h3
`define XCLK_DIV12  2'h0
`define CSEL_PIN    3'h0
`define CSEL_LFO    3'h1
`define CSEL_CMP0   3'h2
`define CSEL_SOF    3'h3

`define IRQ_C0 0
`define IRQ_C1 1
`define IRQ_T2 2
`define IRQ_W  3

`define PIN_C0   0
`define PIN_C1   1
`define PIN_T2   2
`define PIN_XI0  3
`define PIN_XI1  4
`define PIN_LFO  5
`define PIN_CMP0 6
`define PIN_SOF  7
`define PIN_W    8

`endif

/* include/timers_pkg.sv */
// Types shared by the general timer block.
// Assumes an 8-bit register port; takes no widths from timers_cfg.svh.
package timers_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic       ovf;
  } step_t;

endpackage

/* hdl/edge_sync.sv */
// Two-stage synchroniser with edge pulses for asynchronous pins.
// Assumes inputs may change at any time relative to clock_in.
`timescale 1ns/1ps
`default_nettype none

module edge_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock_in,   // system clock
  input  wire logic             resetn_in,  // sync reset, active low
  input  wire logic [WIDTH-1:0] async_in,   // raw pin levels
  output logic      [WIDTH-1:0] level_out,  // synchronised levels
  output logic      [WIDTH-1:0] fall_out,   // high-to-low pulses
  output logic      [WIDTH-1:0] rise_out    // low-to-high pulses
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] prev_ff;

  // First stage is read only by the second stage
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level_out = sync_ff;
  assign fall_out  = prev_ff & ~sync_ff;
  assign rise_out  = ~prev_ff & sync_ff;

endmodule

`default_nettype wire

/* hdl/general_timers.sv */
// Timers 0, 1 and 2 with their register port and one interrupt line.
// Assumes one clock; pins are asynchronous, tick strobes are synchronous.
`include "timers_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module general_timers
  import timers_pkg::*;
(
  input  wire logic     clock_in,              // system clock, 125 MHz
  input  wire logic     resetn_in,             // sync reset, active low
  input  wire reg_req_t bus_in,                // register request
  output logic [7:0]    rdata_out,             // read data, cycle after read
  output logic          irq_out,               // level interrupt
  input  wire logic     div12_tick_in,         // prescaled timer clock strobe
  input  wire logic     ext_tick_in,           // external clock strobe
  input  wire logic     timer0_count_pin_in,   // timer 0 count pin
  input  wire logic     timer1_count_pin_in,   // timer 1 count pin
  input  wire logic     timer2_count_pin_in,   // timer 2 capture pin
  input  wire logic     ext_irq_zero_input_in, // gate input for timer 0
  input  wire logic     ext_irq_one_input_in,  // gate input for timer 1
  input  wire logic     lfo_in,                // low-frequency oscillator
  input  wire logic     cmp0_in,               // comparator 0 output
  input  wire logic     usb_sof_in             // start-of-frame marker
);

  logic [`PIN_W-1:0] pins;
  logic [`PIN_W-1:0] lvl;
  logic [`PIN_W-1:0] fall;
  logic [`PIN_W-1:0] rise;

  logic [7:0] mode_ff;
  logic [7:0] clkc_ff;
  logic [7:0] icfg_ff;
  logic       run0_ff;
  logic       run1_ff;
  logic       tf0_ff;
  logic       tf1_ff;
  logic [7:0] cnt0_lo_ff;
  logic [7:0] cnt0_hi_ff;
  logic [7:0] cnt1_lo_ff;
  logic [7:0] cnt1_hi_ff;
  logic [7:0] t2c_ff;
  logic       t2_hflag_ff;
  logic       t2_lflag_ff;
  logic [2:0] csel_ff;
  logic [7:0] rll_ff;
  logic [7:0] rlh_ff;
  logic [7:0] tl2_ff;
  logic [7:0] th2_ff;
  logic [`IRQ_W-1:0] stat_ff;
  logic [`IRQ_W-1:0] mask_ff;
  logic [`IRQ_W-1:0] nxt_stat;
  logic [7:0] rdata_ff;
  logic       irq_ff;

  assign pins = {usb_sof_in, cmp0_in, lfo_in, ext_irq_one_input_in,
                 ext_irq_zero_input_in, timer2_count_pin_in,
                 timer1_count_pin_in, timer0_count_pin_in};

  edge_sync #(
    .WIDTH (`PIN_W)
  ) u_sync (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .async_in  (pins),
    .level_out (lvl),
    .fall_out  (fall),
    .rise_out  (rise)
  );

  function automatic logic wr_at(input reg_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // One count step of timer 0 or 1 in the given mode
  function automatic step_t step01(input logic [1:0] mode,
                                   input logic [7:0] hi,
                                   input logic [7:0] lo);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    step_t       r;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8  = {1'b0, lo} + 9'h001;
    r.hi  = hi;
    r.lo  = lo;
    r.ovf = 1'b0;
    unique case (mode)
      `MODE_13BIT: begin
        r.hi  = s13[12:5];
        r.lo  = {lo[7:5], s13[4:0]};
        r.ovf = s13[13];
      end
      `MODE_16BIT: begin
        r.hi  = s16[15:8];
        r.lo  = s16[7:0];
        r.ovf = s16[16];
      end
      `MODE_RELOAD: begin
        r.lo  = s8[8] ? hi : s8[7:0];
        r.ovf = s8[8];
      end
      `MODE_SPLIT: begin
        r.lo  = s8[7:0];
        r.ovf = s8[8];
      end
    endcase
    return r;
  endfunction

  // Timer 0 and 1 controls
  logic [1:0] md0;
  logic [1:0] md1;
  logic       irq0_act;
  logic       irq1_act;
  logic       src0;
  logic       src1;
  logic       inc0;
  logic       inc1;
  logic       hi0_inc;
  step_t      step0;
  step_t      step1;
  logic       hi0_roll;
  logic       ovf0;
  logic       ovf1;

  assign md0      = mode_ff[`MOD_SEL0];
  assign md1      = mode_ff[`MOD_SEL1];
  assign irq0_act = lvl[`PIN_XI0] == icfg_ff[`ICF_POL0];
  assign irq1_act = lvl[`PIN_XI1] == icfg_ff[`ICF_POL1];
  assign src0     = mode_ff[`MOD_CNT0] ? fall[`PIN_C0]
                  : (clkc_ff[`CKC_SYS0] | div12_tick_in);
  assign src1     = mode_ff[`MOD_CNT1] ? fall[`PIN_C1]
                  : (clkc_ff[`CKC_SYS1] | div12_tick_in);
  assign inc0     = run0_ff & (~mode_ff[`MOD_GATED0] | irq0_act) & src0;
  assign inc1     = run1_ff & (~mode_ff[`MOD_GATED1] | irq1_act) & src1
                  & (md1 != `MODE_SPLIT);
  assign step0    = step01(md0, cnt0_hi_ff, cnt0_lo_ff);
  assign step1    = step01(md1, cnt1_hi_ff, cnt1_lo_ff);
  // In split mode the high byte borrows timer 1's run bit and flag
  assign hi0_inc  = (md0 == `MODE_SPLIT) & run1_ff
                  & (clkc_ff[`CKC_SYS0] | div12_tick_in);
  assign hi0_roll = hi0_inc & (cnt0_hi_ff == `BYTE_MAX);
  assign ovf0     = inc0 & step0.ovf;
  assign ovf1     = (inc1 & step1.ovf) | hi0_roll;

  // Software writes win over a count in the same cycle
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      cnt0_lo_ff <= `RST_BYTE;
      cnt0_hi_ff <= `RST_BYTE;
    end else begin
      if (inc0) begin
        cnt0_lo_ff <= step0.lo;
        cnt0_hi_ff <= step0.hi;
      end
      if (hi0_inc) begin
        cnt0_hi_ff <= cnt0_hi_ff + 8'h01;
      end
      if (wr_at(bus_in, `OFS_C0_LOW)) begin
        cnt0_lo_ff <= bus_in.wdata;
      end
      if (wr_at(bus_in, `OFS_C0_HIGH)) begin
        cnt0_hi_ff <= bus_in.wdata;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      cnt1_lo_ff <= `RST_BYTE;
      cnt1_hi_ff <= `RST_BYTE;
    end else begin
      if (inc1) begin
        cnt1_lo_ff <= step1.lo;
        cnt1_hi_ff <= step1.hi;
      end
      if (wr_at(bus_in, `OFS_C1_LOW)) begin
        cnt1_lo_ff <= bus_in.wdata;
      end
      if (wr_at(bus_in, `OFS_C1_HIGH)) begin
        cnt1_hi_ff <= bus_in.wdata;
      end
    end
  end

  // Run bits and overflow flags; a hardware set beats a software clear
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      run0_ff <= 1'b0;
      run1_ff <= 1'b0;
      tf0_ff  <= 1'b0;
      tf1_ff  <= 1'b0;
    end else if (wr_at(bus_in, `OFS_RUN_CTRL)) begin
      run0_ff <= bus_in.wdata[`RUN_EN0];
      run1_ff <= bus_in.wdata[`RUN_EN1];
      tf0_ff  <= bus_in.wdata[`RUN_TF0] | ovf0;
      tf1_ff  <= bus_in.wdata[`RUN_TF1] | ovf1;
    end else begin
      tf0_ff  <= tf0_ff | ovf0;
      tf1_ff  <= tf1_ff | ovf1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      mode_ff <= `RST_BYTE;
      clkc_ff <= `RST_BYTE;
      icfg_ff <= `RST_BYTE;
      csel_ff <= `CSEL_PIN;
      mask_ff <= '0;
    end else begin
      if (wr_at(bus_in, `OFS_MODE_CTRL)) begin
        mode_ff <= bus_in.wdata;
      end
      if (wr_at(bus_in, `OFS_CLK_CTRL)) begin
        clkc_ff <= bus_in.wdata;
      end
      if (wr_at(bus_in, `OFS_IRQ_CFG)) begin
        icfg_ff <= bus_in.wdata;
      end
      if (wr_at(bus_in, `OFS_T2_CTRL1)) begin
        csel_ff <= bus_in.wdata[`T2_CSEL];
      end
      if (wr_at(bus_in, `OFS_IRQ_MASK)) begin
        mask_ff <= bus_in.wdata[`IRQ_W-1:0];
      end
    end
  end

  // Timer 2
  logic       split;
  logic       cap_mode;
  logic       t2_ext;
  logic       clk_lo;
  logic       clk_hi;
  logic       lo_inc;
  logic       hi_inc;
  logic       lo_roll;
  logic       hi_roll;
  logic       cap_src;
  logic       cap_evt;
  logic       t2_evt;

  assign split    = t2c_ff[`T2_SPLIT];
  assign cap_mode = t2c_ff[`T2_CEN];
  assign t2_ext   = (t2c_ff[`T2_XCLK] == `XCLK_DIV12) ? div12_tick_in
                  : ext_tick_in;
  assign clk_lo   = clkc_ff[`CKC_SYS2L] | t2_ext;
  assign clk_hi   = clkc_ff[`CKC_SYS2H] | t2_ext;
  assign lo_inc   = clk_lo & (split | t2c_ff[`T2_RUN]);
  assign hi_inc   = split ? (t2c_ff[`T2_RUN] & clk_hi)
                  : (lo_inc & (tl2_ff == `BYTE_MAX));
  assign lo_roll  = lo_inc & (tl2_ff == `BYTE_MAX);
  assign hi_roll  = hi_inc & (th2_ff == `BYTE_MAX);

  always_comb begin
    unique case (csel_ff)
      `CSEL_PIN:  cap_src = fall[`PIN_T2];
      `CSEL_LFO:  cap_src = fall[`PIN_LFO];
      `CSEL_CMP0: cap_src = fall[`PIN_CMP0];
      `CSEL_SOF:  cap_src = rise[`PIN_SOF];
      default:    cap_src = 1'b0;
    endcase
  end

  assign cap_evt = cap_mode & cap_src;

  // Capture mode free-runs: a rollover wraps instead of reloading
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      tl2_ff <= `RST_BYTE;
      th2_ff <= `RST_BYTE;
    end else begin
      if (lo_inc) begin
        if ((split ? lo_roll : hi_roll) && !cap_mode) begin
          tl2_ff <= rll_ff;
        end else begin
          tl2_ff <= tl2_ff + 8'h01;
        end
      end
      if (hi_inc) begin
        th2_ff <= (hi_roll && !cap_mode) ? rlh_ff : th2_ff + 8'h01;
      end
      if (wr_at(bus_in, `OFS_T2_LOW)) begin
        tl2_ff <= bus_in.wdata;
      end
      if (wr_at(bus_in, `OFS_T2_HIGH)) begin
        th2_ff <= bus_in.wdata;
      end
    end
  end

  // A capture beats a software write to the same register
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      rll_ff <= `RST_BYTE;
      rlh_ff <= `RST_BYTE;
    end else if (cap_evt) begin
      rll_ff <= tl2_ff;
      rlh_ff <= th2_ff;
    end else begin
      if (wr_at(bus_in, `OFS_T2_RLD_LOW)) begin
        rll_ff <= bus_in.wdata;
      end
      if (wr_at(bus_in, `OFS_T2_RLD_HIGH)) begin
        rlh_ff <= bus_in.wdata;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      t2c_ff      <= `RST_BYTE;
      t2_hflag_ff <= 1'b0;
      t2_lflag_ff <= 1'b0;
    end else if (wr_at(bus_in, `OFS_T2_CTRL)) begin
      t2c_ff      <= bus_in.wdata;
      t2_hflag_ff <= bus_in.wdata[`T2_HFLAG] | hi_roll;
      t2_lflag_ff <= bus_in.wdata[`T2_LFLAG] | lo_roll;
    end else begin
      t2_hflag_ff <= t2_hflag_ff | hi_roll;
      t2_lflag_ff <= t2_lflag_ff | lo_roll;
    end
  end

  assign t2_evt = hi_roll | (lo_roll & t2c_ff[`T2_LEN]) | cap_evt;

  // Interrupt status: sticky, cleared by reading; a new event wins
  always_comb begin
    nxt_stat = stat_ff;
    if (bus_in.rd && (bus_in.addr == `OFS_IRQ_STATUS)) begin
      nxt_stat = '0;
    end
    nxt_stat[`IRQ_C0] = nxt_stat[`IRQ_C0] | ovf0;
    nxt_stat[`IRQ_C1] = nxt_stat[`IRQ_C1] | ovf1;
    nxt_stat[`IRQ_T2] = nxt_stat[`IRQ_T2] | t2_evt;
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      stat_ff <= '0;
      irq_ff  <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      irq_ff  <= |(nxt_stat & mask_ff);
    end
  end

  // Read mux; unmapped addresses read as zero
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      rdata_ff <= `RST_BYTE;
    end else if (bus_in.rd) begin
      unique case (bus_in.addr)
        `OFS_RUN_CTRL:    rdata_ff <= {tf1_ff, run1_ff, tf0_ff, run0_ff, 4'h0};
        `OFS_MODE_CTRL:   rdata_ff <= mode_ff;
        `OFS_C0_LOW:      rdata_ff <= cnt0_lo_ff;
        `OFS_C1_LOW:      rdata_ff <= cnt1_lo_ff;
        `OFS_C0_HIGH:     rdata_ff <= cnt0_hi_ff;
        `OFS_C1_HIGH:     rdata_ff <= cnt1_hi_ff;
        `OFS_CLK_CTRL:    rdata_ff <= clkc_ff;
        `OFS_T2_CTRL:     rdata_ff <= {t2_hflag_ff, t2_lflag_ff, t2c_ff[5:0]};
        `OFS_T2_RLD_LOW:  rdata_ff <= rll_ff;
        `OFS_T2_RLD_HIGH: rdata_ff <= rlh_ff;
        `OFS_T2_LOW:      rdata_ff <= tl2_ff;
        `OFS_T2_HIGH:     rdata_ff <= th2_ff;
        `OFS_IRQ_CFG:     rdata_ff <= icfg_ff;
        `OFS_IRQ_STATUS:  rdata_ff <= {5'h00, stat_ff};
        `OFS_IRQ_MASK:    rdata_ff <= {5'h00, mask_ff};
        `OFS_T2_CTRL1:    rdata_ff <= {5'h00, csel_ff};
        default:          rdata_ff <= `RST_BYTE;
      endcase
    end else begin
      rdata_ff <= `RST_BYTE;
    end
  end

  assign rdata_out = rdata_ff;
  assign irq_out   = irq_ff;

endmodule

`default_nettype wire

/* sim/general_timers_props.sv */
// Checker for the general timer register port and interrupt line.
// Assumes it is bound to general_timers and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module general_timers_chk
  import timers_pkg::*;
(
  input  wire logic       clock_in,  // system clock
  input  wire logic       resetn_in, // sync reset, active low
  input  wire reg_req_t   bus_in,    // register request
  input  wire logic [7:0] rdata_out, // read data
  input  wire logic       irq_out    // level interrupt
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  logic [2:0] mask_ff;
  logic       cen_ff;

  // Shadow of the mask and capture enable, written only by software
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      mask_ff <= 3'h0;
      cen_ff  <= 1'b0;
    end else if (bus_in.wr && bus_in.addr == 8'hE9) begin
      mask_ff <= bus_in.wdata[2:0];
    end else if (bus_in.wr && bus_in.addr == 8'hC8) begin
      cen_ff <= bus_in.wdata[4];
    end
  end

  reset_quiet_a: assert property (disable iff (1'b0) !resetn_in |=>
    rdata_out == 8'h00 && !irq_out) else $error("outputs not quiet in reset");
  idle_rdata_a: assert property (!bus_in.rd |=> rdata_out == 8'h00)
    else $error("read data outside read cycle");
  unmapped_zero_a: assert property (bus_in.rd && bus_in.addr == 8'h00 |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  mode_readback_a: assert property (bus_in.wr && bus_in.addr == 8'h89 ##2
    bus_in.rd && bus_in.addr == 8'h89 |=> rdata_out == $past(bus_in.wdata, 3))
    else $error("mode register readback");
  reload_readback_a: assert property (bus_in.wr && bus_in.addr == 8'hCA ##2
    bus_in.rd && bus_in.addr == 8'hCA && !cen_ff |=> rdata_out == $past(bus_in.wdata, 3))
    else $error("reload low readback");
  t2_ctrl_back_a: assert property (bus_in.wr && bus_in.addr == 8'hC8 ##2
    bus_in.rd && bus_in.addr == 8'hC8 |=> rdata_out[5:0] == $past(bus_in.wdata[5:0], 3))
    else $error("timer 2 control readback");
  polarity_back_a: assert property (bus_in.wr && bus_in.addr == 8'hE4 ##2
    bus_in.rd && bus_in.addr == 8'hE4 |=> {rdata_out[7], rdata_out[3]} ==
    {$past(bus_in.wdata[7], 3), $past(bus_in.wdata[3], 3)})
    else $error("polarity readback");
  masked_quiet_a: assert property (mask_ff == 3'h0 && $past(mask_ff) == 3'h0 |-> !irq_out)
    else $error("interrupt with all masked");

  cover property ($rose(irq_out));
  cover property (bus_in.rd && bus_in.addr == 8'hE8 ##1 rdata_out != 8'h00);
  cover property (cen_ff && bus_in.rd && bus_in.addr == 8'hCA);
endmodule

bind general_timers general_timers_chk general_timers_chk_inst (
  .clock_in  (clock_in),
  .resetn_in (resetn_in),
  .bus_in    (bus_in),
  .rdata_out (rdata_out),
  .irq_out   (irq_out)
);

`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the general timers: modes, gating, capture, irq.
// Assumes general_timers and its bound checker are compiled before it.
`include "timers_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import timers_pkg::*;
;
  logic               clock_in, resetn_in, div12, ext_tick, irq;
  reg_req_t           bus;
  logic [7:0]         rdata, rv;
  logic [`PIN_W-1:0]  pins;
  int                 failures, cmp_count;

  general_timers general_timers_inst (
    .clock_in(clock_in), .resetn_in(resetn_in), .bus_in(bus), .rdata_out(rdata),
    .irq_out(irq), .div12_tick_in(div12), .ext_tick_in(ext_tick),
    .timer0_count_pin_in(pins[`PIN_C0]), .timer1_count_pin_in(pins[`PIN_C1]),
    .timer2_count_pin_in(pins[`PIN_T2]), .ext_irq_zero_input_in(pins[`PIN_XI0]),
    .ext_irq_one_input_in(pins[`PIN_XI1]), .lfo_in(pins[`PIN_LFO]),
    .cmp0_in(pins[`PIN_CMP0]), .usb_sof_in(pins[`PIN_SOF])
  );

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    bus <= {a, d, 2'b10};
    @(posedge clock_in);
    bus.wr <= 1'b0;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    bus <= {a, 8'h00, 2'b01};
    @(posedge clock_in);
    bus.rd <= 1'b0;
    #1 rv = rdata;
    chk($sformatf("register %h", a), exp, rv);
  endtask

  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clock_in);
    #1 chk("irq", {7'h00, exp}, {7'h00, irq});
  endtask

  // n timer clock strobes, each a cycle wide
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock_in);
      div12 <= 1'b1;
      @(posedge clock_in);
      div12 <= 1'b0;
    end
  endtask

  // Pins are synchronised: leave room for the edge to land
  task automatic pin(input int idx, input logic val);
    @(posedge clock_in);
    pins[idx] <= val;
    repeat (6) @(posedge clock_in);
  endtask

  task automatic t_reset();
    logic [7:0] regs [10] = '{8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hCA, 8'hCB, 8'hCC,
                              8'hCD, 8'h89, 8'hE8};
    foreach (regs[i]) rchk(regs[i], 8'h00);
    rchk(8'h00, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_modes();
    // mode, run, low, high, expected low, expected high
    logic [7:0] tab [4][6] = '{'{8'h00, 8'h10, 8'h1F, 8'h00, 8'h00, 8'h01},
                               '{8'h01, 8'h10, 8'hFF, 8'h00, 8'h00, 8'h01},
                               '{8'h02, 8'h10, 8'hFF, 8'h80, 8'h80, 8'h80},
                               '{8'h03, 8'h50, 8'h10, 8'h20, 8'h11, 8'h21}};
    foreach (tab[i]) begin
      wr(8'h89, tab[i][0]);
      rchk(8'h89, tab[i][0]);
      wr(8'h8A, tab[i][2]);
      wr(8'h8C, tab[i][3]);
      wr(8'h88, tab[i][1]);
      tick(1);
      wr(8'h88, 8'h00);
      tick(1);
      rchk(8'h8A, tab[i][4]);
      rchk(8'h8C, tab[i][5]);
    end
    rchk(8'hE8, 8'h01);
    $display("test modes done");
  endtask

  task automatic t_gate();
    wr(8'hE4, 8'h80);
    rchk(8'hE4, 8'h80);
    wr(8'h89, 8'h99);
    wr(8'h8A, 8'h00);
    wr(8'h8B, 8'h00);
    wr(8'h88, 8'h50);
    tick(2);
    pin(`PIN_XI0, 1'b1);
    pin(`PIN_XI1, 1'b1);
    tick(3);
    wr(8'h88, 8'h00);
    rchk(8'h8A, 8'h02);
    rchk(8'h8B, 8'h03);
    $display("test gate done");
  endtask

  task automatic t_count();
    wr(8'h89, 8'h55);
    wr(8'h8A, 8'h00);
    wr(8'h8B, 8'h00);
    wr(8'h88, 8'h50);
    tick(2);
    repeat (3) begin
      pin(`PIN_C0, 1'b1);
      pin(`PIN_C0, 1'b0);
      pin(`PIN_C1, 1'b1);
      pin(`PIN_C1, 1'b0);
    end
    wr(8'h88, 8'h00);
    rchk(8'h8A, 8'h03);
    rchk(8'h8B, 8'h03);
    wr(8'h89, 8'h30);
    wr(8'h8B, 8'h42);
    wr(8'h88, 8'h40);
    tick(3);
    rchk(8'h8B, 8'h42);
    $display("test count done");
  endtask

  task automatic t_t2();
    wr(8'hE9, 8'h04);
    wr(8'hCA, 8'h34);
    rchk(8'hCA, 8'h34);
    wr(8'hCB, 8'h12);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h04);
    rchk(8'hC8, 8'h04);
    tick(1);
    irq_chk(1'b1);
    rchk(8'hC8, 8'hC4);
    rchk(8'hCC, 8'h34);
    rchk(8'hCD, 8'h12);
    rchk(8'hE8, 8'h04);
    irq_chk(1'b0);
    wr(8'hE9, 8'h00);
    wr(8'hCA, 8'h55);
    wr(8'hCB, 8'h66);
    wr(8'hCC, 8'hFF);
    wr(8'hC8, 8'h28);
    tick(1);
    rchk(8'hCC, 8'h55);
    rchk(8'hCD, 8'h12);
    rchk(8'hC8, 8'h68);
    irq_chk(1'b0);
    rchk(8'hE8, 8'h04);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h2C);
    tick(1);
    rchk(8'hCC, 8'h56);
    rchk(8'hCD, 8'h66);
    rchk(8'hC8, 8'hAC);
    rchk(8'hE8, 8'h04);
    $display("test timer2 done");
  endtask

  task automatic t_capture();
    int src [4] = '{`PIN_T2, `PIN_LFO, `PIN_CMP0, `PIN_SOF};
    wr(8'hE9, 8'h04);
    wr(8'hC8, 8'h10);
    irq_chk(1'b0);
    foreach (src[i]) begin
      wr(8'hFD, 8'(i));
      wr(8'hCC, 8'hA0 + 8'(i));
      wr(8'hCD, 8'h5A);
      pin(src[i], 1'b1);
      pin(src[i], 1'b0);
      irq_chk(1'b1);
      rchk(8'hCA, 8'hA0 + 8'(i));
      rchk(8'hCB, 8'h5A);
      rchk(8'hE8, 8'h04);
    end
    $display("test capture done");
  endtask

  // External tick only counts once selected; system clock counts every cycle
  task automatic t_extclk();
    wr(8'hC8, 8'h05);
    wr(8'hCC, 8'h10);
    tick(2);
    @(posedge clock_in);
    ext_tick <= 1'b1;
    @(posedge clock_in);
    ext_tick <= 1'b0;
    rchk(8'hCC, 8'h11);
    wr(8'h8E, 8'h10);
    wr(8'hC8, 8'h01);
    rchk(8'h8E, 8'h10);
    rchk(8'hCC, 8'h13);
    $display("test clock select done");
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  initial begin
    #200us;
    failures++;
    stop_test();
  end

  initial begin
    failures = 0;
    cmp_count = 0;
    bus = '0;
    div12 = 1'b0;
    ext_tick = 1'b0;
    pins = '0;
    resetn_in = 1'b0;
    repeat (6) @(posedge clock_in);
    resetn_in <= 1'b1;
    t_reset();
    t_modes();
    t_gate();
    t_count();
    t_t2();
    t_capture();
    t_extclk();
    stop_test();
  end
endmodule

`default_nettype wire
